// >>> hdl/aba_pkg.sv
// shared constants, types and round functions of the aes block accelerator
package aba_pkg;

  // cycles from an accepted start to a finished block
  localparam int         ABA_CYC_KEY128    = 52;
  localparam int         ABA_CYC_KEY256    = 75;
  // round counts and key schedule
  localparam int         ABA_ROUNDS_KEY128 = 10;
  localparam int         ABA_ROUNDS_KEY256 = 14;
  localparam int         ABA_MAX_ROUNDS    = 14;
  localparam int         ABA_FIRST_KIDX128 = 1;
  localparam int         ABA_FIRST_KIDX256 = 2;
  localparam logic [7:0] ABA_RCON_INIT     = 8'h01;
  // field arithmetic
  localparam logic [7:0] ABA_GF_POLY       = 8'h1B;
  localparam logic [7:0] ABA_AFFINE_C      = 8'h63;
  localparam logic [7:0] ABA_INV_AFFINE_C  = 8'h05;
  // values after reset
  localparam logic [127:0] ABA_DATA_RESET  = 128'h0;
  localparam logic [6:0]   ABA_CNT_RESET   = 7'h00;

  typedef enum logic [2:0] {
    ABA_IDLE   = 3'b000,
    ABA_EXPAND = 3'b001,
    ABA_WHITEN = 3'b010,
    ABA_ROUND  = 3'b011,
    ABA_WAIT   = 3'b100
  } aba_state_t;

  typedef struct packed {
    logic         start;
    logic         decrypt;
    logic         key256;
    logic [255:0] key;
    logic [127:0] data;
  } aba_req_t;

  typedef struct packed {
    logic         done;
    logic         busy;
    logic [127:0] data;
  } aba_rsp_t;

  function automatic logic [7:0] aba_xtime(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? ABA_GF_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] aba_gf_mul(input logic [7:0] a,
                                            input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = aba_xtime(x);
    end
    return p;
  endfunction

  // byte n sits at bits 127-8n, column c holds bytes 4c..4c+3
  function automatic logic [127:0] aba_shift_rows(input logic [127:0] s,
                                                  input logic inv);
    logic [127:0] o;
    int           src;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        src = inv ? ((c - r + 4) % 4) : ((c + r) % 4);
        o[127-8*(4*c+r) -: 8] = s[127-8*(4*src+r) -: 8];
      end
    end
    return o;
  endfunction

  function automatic logic [127:0] aba_mix_columns(input logic [127:0] s,
                                                   input logic inv);
    logic [127:0] o;
    logic [7:0]   a0, a1, a2, a3, m0, m1, m2, m3;
    o  = '0;
    m0 = inv ? 8'h0E : 8'h02;
    m1 = inv ? 8'h0B : 8'h03;
    m2 = inv ? 8'h0D : 8'h01;
    m3 = inv ? 8'h09 : 8'h01;
    for (int c = 0; c < 4; c++) begin
      a0 = s[127-32*c -: 8];
      a1 = s[119-32*c -: 8];
      a2 = s[111-32*c -: 8];
      a3 = s[103-32*c -: 8];
      o[127-32*c -: 8] = aba_gf_mul(a0, m0) ^ aba_gf_mul(a1, m1) ^
                         aba_gf_mul(a2, m2) ^ aba_gf_mul(a3, m3);
      o[119-32*c -: 8] = aba_gf_mul(a0, m3) ^ aba_gf_mul(a1, m0) ^
                         aba_gf_mul(a2, m1) ^ aba_gf_mul(a3, m2);
      o[111-32*c -: 8] = aba_gf_mul(a0, m2) ^ aba_gf_mul(a1, m3) ^
                         aba_gf_mul(a2, m0) ^ aba_gf_mul(a3, m1);
      o[103-32*c -: 8] = aba_gf_mul(a0, m1) ^ aba_gf_mul(a1, m2) ^
                         aba_gf_mul(a2, m3) ^ aba_gf_mul(a3, m0);
    end
    return o;
  endfunction

endpackage

// >>> hdl/aba_sbox.sv
// forward or inverse substitution of one byte
`timescale 1ns/1ps
`default_nettype none
module aba_sbox
  import aba_pkg::*;
(
  // byte in
  input  wire logic [7:0] i_byte,
  input  wire logic       i_inverse,
  // byte out
  output logic      [7:0] o_byte
);

  function automatic logic [7:0] gf_inv(input logic [7:0] x);
    logic [7:0] r;
    r = x;
    for (int i = 0; i < 6; i++) begin
      r = aba_gf_mul(aba_gf_mul(r, r), x);
    end
    return aba_gf_mul(r, r);
  endfunction

  wire logic [7:0] fwd_in = i_byte;
  wire logic [7:0] inv_in = {i_byte[6:0], i_byte[7]}
                          ^ {i_byte[4:0], i_byte[7:5]}
                          ^ {i_byte[1:0], i_byte[7:2]} ^ ABA_INV_AFFINE_C;
  wire logic [7:0] recip  = gf_inv(i_inverse ? inv_in : fwd_in);
  wire logic [7:0] affine = recip ^ {recip[6:0], recip[7]}
                          ^ {recip[5:0], recip[7:6]}
                          ^ {recip[4:0], recip[7:5]}
                          ^ {recip[3:0], recip[7:4]} ^ ABA_AFFINE_C;

  assign o_byte = i_inverse ? recip : affine;

endmodule // aba_sbox
`default_nettype wire

// >>> hdl/aba_core.sv
// aes block accelerator: key schedule, rounds and fixed latency
`timescale 1ns/1ps
`default_nettype none
module aba_core
  import aba_pkg::*;
(
  // clock and reset
  input  wire logic     i_clock,
  input  wire logic     i_reset_n,
  // request from the bus side
  input  wire aba_req_t i_req,
  // answer to the bus side
  output aba_rsp_t      o_rsp
);

  aba_state_t   st;
  logic [6:0]   cnt;
  logic         decrypt;
  logic         key256;
  logic         done;
  logic         rot_step;
  logic [3:0]   kidx;
  logic [3:0]   ridx;
  logic [7:0]   rcon;
  logic [127:0] blk;
  logic [127:0] data_in;
  logic [127:0] result;
  logic [127:0] lo;
  logic [127:0] hi;
  logic [127:0] rk_mem [0:ABA_MAX_ROUNDS];

  // decode
  wire logic       accept   = i_req.start && (st == ABA_IDLE);
  wire logic [3:0] nr       = key256 ? 4'(ABA_ROUNDS_KEY256)
                                     : 4'(ABA_ROUNDS_KEY128);
  wire logic [6:0] target   = key256 ? 7'(ABA_CYC_KEY256)
                                     : 7'(ABA_CYC_KEY128);
  wire logic       finish   = (st == ABA_WAIT) && (cnt == target);
  wire logic       last_rnd = decrypt ? (ridx == 4'h0) : (ridx == nr);
  wire logic       last_key = (kidx == nr);
  wire logic [3:0] ridx_nxt = decrypt ? 4'(ridx - 4'h1) : 4'(ridx + 4'h1);

  // round datapath
  logic [127:0] sub_state;
  logic [31:0]  sub_word;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_state_sbox
      aba_sbox u_sbox (
        .i_byte    (blk[127-8*g -: 8]),
        .i_inverse (decrypt),
        .o_byte    (sub_state[127-8*g -: 8])
      );
    end
  endgenerate

  wire logic [127:0] rk_cur  = rk_mem[ridx];
  wire logic [127:0] shifted = aba_shift_rows(sub_state, decrypt);
  wire logic [127:0] enc_out = (last_rnd ? shifted
                               : aba_mix_columns(shifted, 1'b0)) ^ rk_cur;
  wire logic [127:0] dec_key = shifted ^ rk_cur;
  wire logic [127:0] dec_out = last_rnd ? dec_key
                               : aba_mix_columns(dec_key, 1'b1);
  wire logic [127:0] rnd_out = decrypt ? dec_out : enc_out;

  // key schedule, four words per cycle
  wire logic [31:0] last_w = lo[31:0];
  wire logic [31:0] sub_in = rot_step ? {last_w[23:0], last_w[31:24]}
                                      : last_w;

  generate
    for (g = 0; g < 4; g++) begin : g_key_sbox
      aba_sbox u_sbox (
        .i_byte    (sub_in[31-8*g -: 8]),
        .i_inverse (1'b0),
        .o_byte    (sub_word[31-8*g -: 8])
      );
    end
  endgenerate

  wire logic [31:0]  tword = sub_word ^ (rot_step ? {rcon, 24'h000000}
                                                  : 32'h00000000);
  wire logic [127:0] base  = key256 ? hi : lo;
  wire logic [31:0]  n0    = base[127:96] ^ tword;
  wire logic [31:0]  n1    = base[95:64] ^ n0;
  wire logic [31:0]  n2    = base[63:32] ^ n1;
  wire logic [31:0]  n3    = base[31:0] ^ n2;

  // round key store
  always_ff @(posedge i_clock) begin
    if (accept) begin
      rk_mem[0] <= i_req.key[255:128];
      rk_mem[1] <= i_req.key[127:0];
    end else if (st == ABA_EXPAND) begin
      rk_mem[kidx] <= {n0, n1, n2, n3};
    end
  end

  // latency counter
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt <= ABA_CNT_RESET;
    end else if (accept) begin
      cnt <= 7'h01;
    end else if (st != ABA_IDLE) begin
      cnt <= cnt + 7'h01;
    end
  end

  // sequencer
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st       <= ABA_IDLE;
      decrypt  <= 1'b0;
      key256   <= 1'b0;
      done     <= 1'b0;
      rot_step <= 1'b1;
      kidx     <= 4'h0;
      ridx     <= 4'h0;
      rcon     <= ABA_RCON_INIT;
      blk      <= ABA_DATA_RESET;
      data_in  <= ABA_DATA_RESET;
      result   <= ABA_DATA_RESET;
      lo       <= ABA_DATA_RESET;
      hi       <= ABA_DATA_RESET;
    end else begin
      case (st)
        ABA_IDLE: begin
          if (accept) begin
            decrypt  <= i_req.decrypt;
            key256   <= i_req.key256;
            data_in  <= i_req.data;
            hi       <= i_req.key[255:128];
            lo       <= i_req.key256 ? i_req.key[127:0]
                                     : i_req.key[255:128];
            kidx     <= i_req.key256 ? 4'(ABA_FIRST_KIDX256)
                                     : 4'(ABA_FIRST_KIDX128);
            rot_step <= 1'b1;
            rcon     <= ABA_RCON_INIT;
            done     <= 1'b0;
            st       <= ABA_EXPAND;
          end
        end
        ABA_EXPAND: begin
          lo       <= {n0, n1, n2, n3};
          hi       <= lo;
          kidx     <= kidx + 4'h1;
          rcon     <= rot_step ? aba_xtime(rcon) : rcon;
          rot_step <= key256 ? ~rot_step : 1'b1;
          if (last_key) begin
            ridx <= decrypt ? nr : 4'h0;
            st   <= ABA_WHITEN;
          end
        end
        ABA_WHITEN: begin
          blk  <= data_in ^ rk_cur;
          ridx <= ridx_nxt;
          st   <= ABA_ROUND;
        end
        ABA_ROUND: begin
          blk <= rnd_out;
          if (last_rnd) begin
            st <= ABA_WAIT;
          end else begin
            ridx <= ridx_nxt;
          end
        end
        ABA_WAIT: begin
          if (finish) begin
            result <= blk;
            done   <= 1'b1;
            st     <= ABA_IDLE;
          end
        end
        default: begin
          st <= ABA_IDLE;
        end
      endcase
    end
  end

  assign o_rsp = '{done: done, busy: (st != ABA_IDLE), data: result};

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  AST_LAT128: assert property (
    accept && !i_req.key256 |-> ##52 (finish && !o_rsp.done) ##1 o_rsp.done)
    else $error("128-bit key block not finished after 52 cycles");
  AST_LAT256: assert property (
    accept && i_req.key256 |-> ##75 (finish && !o_rsp.done) ##1 o_rsp.done)
    else $error("256-bit key block not finished after 75 cycles");
  AST_NO_EARLY: assert property (
    accept |=> !o_rsp.done [*8])
    else $error("completion flag seen too early");
  AST_ROUNDS_FIT: assert property (
    accept |-> ##[10:30] (st == ABA_WAIT))
    else $error("rounds did not end before the wait phase");
  AST_BUSY_HELD: assert property (
    accept |=> o_rsp.busy throughout (##[1:74] finish))
    else $error("busy dropped while a block was in flight");
  AST_DONE_HOLD: assert property (
    o_rsp.done && !accept |=> o_rsp.done && $stable(o_rsp.data))
    else $error("completion flag or result lost before next start");
  AST_IGNORE_BUSY: assert property (
    i_req.start && o_rsp.busy |=> $stable(decrypt) && $stable(key256))
    else $error("start taken while busy");

  COV_ENC128: cover property (
    accept && !i_req.decrypt && !i_req.key256 ##52 finish);
  COV_DEC256: cover property (
    accept && i_req.decrypt && i_req.key256 ##75 finish);
  COV_START_BUSY: cover property (o_rsp.busy && i_req.start);

endmodule // aba_core
`default_nettype wire

// >>> verification/aba_master_model.sv
// bus master model handing whole requests to the accelerator
`timescale 1ns/1ps
`default_nettype none
module aba_master_model
  import aba_pkg::*;
(
  // clock and answer
  input  wire logic     i_clock,
  input  wire logic     i_busy,
  // request
  output var  aba_req_t o_req
);
  initial o_req = '0;

  // waits for idle, holds start one edge, then scrambles released fields
  task automatic issue(input logic dec, input logic k256,
                       input logic [255:0] key, input logic [127:0] din,
                       input int gap);
    repeat (gap) @(negedge i_clock);
    while (i_busy !== 1'b0) @(negedge i_clock);
    o_req = '{1'b1, dec, k256, key, din};
    @(negedge i_clock);
    o_req = '{1'b0, ~dec, ~k256, ~key, ~din};
  endtask

  // start raised while busy, expected to be ignored
  task automatic poke(input logic [255:0] key, input logic [127:0] din);
    o_req = '{1'b1, 1'b1, 1'b0, key, din};
    @(negedge i_clock);
    o_req.start = 1'b0;
  endtask
endmodule // aba_master_model
`default_nettype wire

// >>> verification/aes_block_accelerator_tb.sv
// self-checking bench of the aes block accelerator
`timescale 1ns/1ps
`default_nettype none
module aes_block_accelerator_tb;
  import aba_pkg::*;
  logic     i_clock;
  logic     i_reset_n;
  aba_req_t req;
  aba_rsp_t rsp;
  int       n_errors = 0;
  int       checked  = 0;

  localparam logic [255:0] K128 = {128'h000102030405060708090A0B0C0D0E0F,
                                   128'h5A5A5A5AC3C3C3C30F0F0F0F96969696};
  localparam logic [255:0] K256 =
    256'h000102030405060708090A0B0C0D0E0F101112131415161718191A1B1C1D1E1F;
  localparam logic [127:0] PT   = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] C128 = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  localparam logic [127:0] C256 = 128'h8EA2B7CA516745BFEAFC49904B496089;

  aba_master_model master_u (
    .i_clock (i_clock),
    .i_busy  (rsp.busy),
    .o_req   (req)
  );

  aba_core dut_u (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_req     (req),
    .o_rsp     (rsp)
  );

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  task automatic complete_run;
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check_blk(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one block from start to finish, counting cycles after the start edge
  task automatic run_block(input logic dec, input logic k256,
                           input logic [255:0] key, input logic [127:0] din,
                           input logic [127:0] exp, input int ncyc,
                           input bit mid);
    int n;
    n = 0;
    master_u.issue(dec, k256, key, din, 0);
    check_bit(rsp.busy, 1'b1);
    check_bit(rsp.done, 1'b0);
    if (mid) begin
      @(negedge i_clock);
      n++;
      master_u.poke(~key, ~din);
      n++;
    end
    while (rsp.done !== 1'b1 && n < 200) begin
      @(negedge i_clock);
      n++;
    end
    check_cnt(n, ncyc);
    check_blk(rsp.data, exp);
    check_bit(rsp.busy, 1'b0);
  endtask

  task automatic t_enc128;
    run_block(1'b0, 1'b0, K128, PT, C128, ABA_CYC_KEY128, 1'b0);
  endtask

  task automatic t_dec128_back_to_back;
    run_block(1'b1, 1'b0, K128, C128, PT, ABA_CYC_KEY128, 1'b0);
  endtask

  task automatic t_enc256_refused_start;
    run_block(1'b0, 1'b1, K256, PT, C256, ABA_CYC_KEY256, 1'b1);
  endtask

  task automatic t_dec256_hold;
    run_block(1'b1, 1'b1, K256, C256, PT, ABA_CYC_KEY256, 1'b0);
    repeat (4) @(negedge i_clock);
    check_bit(rsp.done, 1'b1);
    check_blk(rsp.data, PT);
  endtask

  task automatic t_reset_mid_block;
    master_u.issue(1'b0, 1'b1, K256, PT, 0);
    repeat (10) @(negedge i_clock);
    i_reset_n = 1'b0;
    @(negedge i_clock);
    check_bit(rsp.done, 1'b0);
    check_bit(rsp.busy, 1'b0);
    check_blk(rsp.data, ABA_DATA_RESET);
    i_reset_n = 1'b1;
    run_block(1'b0, 1'b0, K128, PT, C128, ABA_CYC_KEY128, 1'b0);
  endtask

  initial begin
    repeat (3000) @(posedge i_clock);
    n_errors++;
    complete_run();
  end

  initial begin
    i_reset_n = 1'b0;
    repeat (3) @(negedge i_clock);
    i_reset_n = 1'b1;
    t_enc128();
    t_dec128_back_to_back();
    t_enc256_refused_start();
    t_dec256_hold();
    t_reset_mid_block();
    complete_run();
  end
endmodule // aes_block_accelerator_tb
`default_nettype wire
